// file: core/phy_test_ctrl.sv
`timescale 1ns/1ps
// Function
// - Loopback bit routes transmit frames back to the receive path
// - Speed bit selects 10 or 100 Mbps when forced
// - Auto-negotiation bit clear makes forced speed and duplex apply
// - Duplex bit one forces full duplex, needed by both loopbacks; neither loopback enable is gated on it here
// - Local loopback also transmits on copper unless reduced interface
// - Remote loopback works only at 100 Mbps full duplex, wraps line frames
// - Control-two bit 2 enables remote loopback
// - Start bit launches diagnostic; hardware clears it on completion
// - Result bits 14:13 give normal, open, short or invalid
// - If partner stays active, skip measurement and report invalid
// - Nine-bit fault distance count in bits 8:0
// - In chain mode every input feeds a nested NAND to the output pin
// - Chain mode enabled by active-low strap or test-mode bit 5
// - Each falling chain input inverts the chain output
// - Control-two bit 10 enables power saving with autoneg on, no link
// - Energy-detect bit 11 zero enables power-down with autoneg, no link
// - PLL-power bit 4 turns PLL off during energy-detect power-down
// - Basic bit 11 powers down all but management; clearing exits
// - Oscillator bit 5 selects the on-chip slow oscillator
module phy_test_ctrl
    import phy_test_pkg::*;
#(
    parameter int QUIET_CNT = QUIET_CYCLES,
    parameter int ECHO_CNT  = ECHO_CYCLES
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    // Management register access
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [4:0]  REG_ADDR,
    input  wire logic [15:0] REG_WDATA,
    output logic [15:0]      REG_RDATA,
    // Link and interface status
    input  wire logic        LINK_UP,
    input  wire logic        LINK_100_FULL,
    input  wire logic        RMII_MODE,
    // Reflectometry front end
    input  wire logic        LINE_ENERGY,
    input  wire logic        ECHO_SEEN,
    input  wire logic        ECHO_SHORT,
    output logic             REFLECT_PULSE,
    output logic             PARTNER_QUIET_REQ,
    // Chain test pins
    input  wire logic        CHAIN_STRAP_N,
    input  wire logic [16:0] CHAIN_PINS,
    output logic             CHAIN_OUTPUT_PIN,
    output logic             CHAIN_OUTPUT_OE_N,
    // Datapath and power controls
    output logic             LOCAL_LOOP_EN,
    output logic             LOCAL_COPPER_TX_EN,
    output logic             REMOTE_LOOP_EN,
    output logic             SPEED_100,
    output logic             FULL_DUPLEX,
    output logic             AUTONEG_EN,
    output logic             POWER_SAVE_ACTIVE,
    output logic             ENERGY_DETECT_POWERDOWN,
    output logic             PLL_ENABLE,
    output logic             CORE_POWER_DOWN,
    output logic             SLOW_OSC_SELECT,
    output logic             SOFT_RESET_PULSE
);

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [15:0] basic_control_reg;
    logic [15:0] pll_power_reg;
    logic [15:0] oscillator_reg;
    logic [15:0] test_mode_reg;
    logic [15:0] energy_detect_reg;
    logic [15:0] phy_control_two_reg;
    logic        diag_start_reg;
    logic [1:0]  diag_result_reg;
    logic [8:0]  diag_dist_reg;
    diag_state_t diag_state_reg;
    logic [15:0] diag_cnt_reg;

    // Pin synchronisers
    logic [1:0]  strap_sync_reg;
    logic [16:0] pins_meta_reg;
    logic [16:0] pins_sync_reg;
    logic [2:0]  line_meta_reg;
    logic [2:0]  line_sync_reg;
    logic [2:0]  link_meta_reg;
    logic [2:0]  link_sync_reg;

    logic        chain_out;
    logic        chain_mode;
    logic        wr_basic;
    logic        diag_done_evt;

    function automatic logic hit(input logic [4:0] a);
        return REG_WR && (REG_ADDR == a);
    endfunction : hit

    assign wr_basic = REG_WR && (REG_ADDR == ADDR_BASIC_CONTROL);

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers for pins
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            strap_sync_reg <= 2'h3;
            pins_meta_reg  <= 17'h1ffff;
            pins_sync_reg  <= 17'h1ffff;
            line_meta_reg  <= 3'h0;
            line_sync_reg  <= 3'h0;
            link_meta_reg  <= 3'h0;
            link_sync_reg  <= 3'h0;
        end else begin
            strap_sync_reg <= {strap_sync_reg[0], CHAIN_STRAP_N};
            pins_meta_reg  <= CHAIN_PINS;
            pins_sync_reg  <= pins_meta_reg;
            line_meta_reg  <= {LINE_ENERGY, ECHO_SEEN, ECHO_SHORT};
            line_sync_reg  <= line_meta_reg;
            link_meta_reg  <= {LINK_UP, LINK_100_FULL, RMII_MODE};
            link_sync_reg  <= link_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Basic control register; soft reset restores defaults
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            basic_control_reg <= BASIC_CONTROL_RESET;
            SOFT_RESET_PULSE  <= 1'b0;
        end else begin
            SOFT_RESET_PULSE <= wr_basic && REG_WDATA[BC_SOFT_RESET];
            if (wr_basic && REG_WDATA[BC_SOFT_RESET]) begin
                basic_control_reg <= BASIC_CONTROL_RESET;
            end else if (wr_basic) begin
                basic_control_reg <= REG_WDATA & 16'h7fff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Plain control registers
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            pll_power_reg       <= ZERO_RESET;
            oscillator_reg      <= ZERO_RESET;
            test_mode_reg       <= ZERO_RESET;
            energy_detect_reg   <= ENERGY_DETECT_RESET;
            phy_control_two_reg <= ZERO_RESET;
        end else begin
            if (hit(ADDR_PLL_POWER)) begin
                pll_power_reg <= REG_WDATA;
            end
            if (hit(ADDR_OSCILLATOR)) begin
                oscillator_reg <= REG_WDATA;
            end
            if (hit(ADDR_TEST_MODE)) begin
                test_mode_reg <= REG_WDATA;
            end
            if (hit(ADDR_ENERGY_DETECT)) begin
                energy_detect_reg <= REG_WDATA;
            end
            if (hit(ADDR_PHY_CONTROL_TWO)) begin
                phy_control_two_reg <= REG_WDATA;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cable diagnostic sequencer
    assign diag_done_evt = (diag_state_reg == DIAG_DONE);

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            diag_state_reg    <= DIAG_IDLE;
            diag_cnt_reg      <= 16'h0000;
            diag_start_reg    <= 1'b0;
            diag_result_reg   <= RESULT_NORMAL;
            diag_dist_reg     <= 9'h000;
            REFLECT_PULSE     <= 1'b0;
            PARTNER_QUIET_REQ <= 1'b0;
        end else begin
            REFLECT_PULSE <= 1'b0;
            unique case (diag_state_reg)
                DIAG_IDLE: begin
                    if (hit(ADDR_CABLE_DIAG) && REG_WDATA[CD_START]) begin
                        diag_start_reg    <= 1'b1;
                        diag_cnt_reg      <= 16'h0000;
                        PARTNER_QUIET_REQ <= 1'b1;
                        diag_state_reg    <= DIAG_QUIET;
                    end
                end
                DIAG_QUIET: begin
                    diag_cnt_reg <= diag_cnt_reg + 16'h0001;
                    if (diag_cnt_reg == 16'(QUIET_CNT - 1)) begin
                        diag_cnt_reg <= 16'h0000;
                        if (line_sync_reg[2]) begin
                            diag_result_reg <= RESULT_INVALID;
                            diag_dist_reg   <= 9'h000;
                            diag_state_reg  <= DIAG_DONE;
                        end else begin
                            REFLECT_PULSE  <= 1'b1;
                            diag_state_reg <= DIAG_PULSE;
                        end
                    end
                end
                DIAG_PULSE: begin
                    diag_state_reg <= DIAG_LISTEN;
                end
                DIAG_LISTEN: begin
                    diag_cnt_reg <= diag_cnt_reg + 16'h0001;
                    if (line_sync_reg[1]) begin
                        diag_result_reg <= line_sync_reg[0] ? RESULT_SHORT : RESULT_OPEN;
                        diag_dist_reg   <= diag_cnt_reg[8:0];
                        diag_state_reg  <= DIAG_DONE;
                    end else if (diag_cnt_reg == 16'(ECHO_CNT - 1)) begin
                        diag_result_reg <= RESULT_NORMAL;
                        diag_dist_reg   <= 9'h000;
                        diag_state_reg  <= DIAG_DONE;
                    end
                end
                DIAG_DONE: begin
                    diag_start_reg    <= 1'b0;
                    PARTNER_QUIET_REQ <= 1'b0;
                    diag_state_reg    <= DIAG_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Chain test
    nand_chain #(
        .N(CHAIN_INPUTS)
    ) u_chain (
        .clk       (CLK),
        .reset_n   (RESET_N),
        .chain_in  (pins_sync_reg),
        .chain_out (chain_out)
    );

    assign chain_mode = !strap_sync_reg[1] || test_mode_reg[TM_CHAIN_ENABLE];

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            CHAIN_OUTPUT_PIN  <= 1'b0;
            CHAIN_OUTPUT_OE_N <= 1'b1;
        end else begin
            CHAIN_OUTPUT_PIN  <= chain_out;
            CHAIN_OUTPUT_OE_N <= !chain_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Datapath and power outputs
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            LOCAL_LOOP_EN           <= 1'b0;
            LOCAL_COPPER_TX_EN      <= 1'b0;
            REMOTE_LOOP_EN          <= 1'b0;
            SPEED_100               <= 1'b1;
            FULL_DUPLEX             <= 1'b1;
            AUTONEG_EN              <= 1'b1;
            POWER_SAVE_ACTIVE       <= 1'b0;
            ENERGY_DETECT_POWERDOWN <= 1'b0;
            PLL_ENABLE              <= 1'b1;
            CORE_POWER_DOWN         <= 1'b0;
            SLOW_OSC_SELECT         <= 1'b0;
        end else begin
            LOCAL_LOOP_EN      <= basic_control_reg[BC_LOOPBACK];
            LOCAL_COPPER_TX_EN <= basic_control_reg[BC_LOOPBACK] && !link_sync_reg[0];
            SPEED_100          <= basic_control_reg[BC_SPEED_100];
            AUTONEG_EN         <= basic_control_reg[BC_AUTONEG_EN];
            FULL_DUPLEX        <= basic_control_reg[BC_FULL_DUPLEX];
            REMOTE_LOOP_EN     <= phy_control_two_reg[P2_REMOTE_LOOP] && link_sync_reg[1];
            POWER_SAVE_ACTIVE  <= phy_control_two_reg[P2_POWER_SAVE]
                                  && basic_control_reg[BC_AUTONEG_EN] && !link_sync_reg[2];
            ENERGY_DETECT_POWERDOWN <= !energy_detect_reg[ED_DISABLE_BIT]
                                       && basic_control_reg[BC_AUTONEG_EN] && !link_sync_reg[2];
            PLL_ENABLE         <= !(pll_power_reg[PLL_OFF_IN_ENERGY_DETECT_POWERDOWN] && !energy_detect_reg[ED_DISABLE_BIT]
                                    && basic_control_reg[BC_AUTONEG_EN] && !link_sync_reg[2])
                                  && !basic_control_reg[BC_POWER_DOWN];
            CORE_POWER_DOWN    <= basic_control_reg[BC_POWER_DOWN];
            SLOW_OSC_SELECT    <= oscillator_reg[OSC_SLOW_SELECT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, registered one cycle after the read strobe
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            REG_RDATA <= 16'h0000;
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                ADDR_BASIC_CONTROL:   REG_RDATA <= basic_control_reg;
                ADDR_PLL_POWER:       REG_RDATA <= pll_power_reg;
                ADDR_OSCILLATOR:      REG_RDATA <= oscillator_reg;
                ADDR_TEST_MODE:       REG_RDATA <= test_mode_reg;
                ADDR_ENERGY_DETECT:   REG_RDATA <= energy_detect_reg;
                ADDR_CABLE_DIAG:      REG_RDATA <= {diag_start_reg && !diag_done_evt, diag_result_reg,
                                                    4'h0, diag_dist_reg};
                ADDR_PHY_CONTROL_TWO: REG_RDATA <= phy_control_two_reg;
                default:              REG_RDATA <= 16'h0000;
            endcase
        end
    end

endmodule : phy_test_ctrl

// file: include/phy_test_pkg.sv
package phy_test_pkg;

    // Register addresses on the management bus
    localparam logic [4:0] ADDR_BASIC_CONTROL    = 5'h00;
    localparam logic [4:0] ADDR_PLL_POWER        = 5'h10;
    localparam logic [4:0] ADDR_OSCILLATOR       = 5'h11;
    localparam logic [4:0] ADDR_TEST_MODE        = 5'h16;
    localparam logic [4:0] ADDR_ENERGY_DETECT    = 5'h18;
    localparam logic [4:0] ADDR_CABLE_DIAG       = 5'h1d;
    localparam logic [4:0] ADDR_PHY_CONTROL_TWO  = 5'h1f;

    // Basic control fields
    localparam int BC_SOFT_RESET   = 15;
    localparam int BC_LOOPBACK     = 14;
    localparam int BC_SPEED_100    = 13;
    localparam int BC_AUTONEG_EN   = 12;
    localparam int BC_POWER_DOWN   = 11;
    localparam int BC_FULL_DUPLEX  = 8;

    // Other control fields
    localparam int PLL_OFF_IN_ENERGY_DETECT_POWERDOWN = 4;
    localparam int OSC_SLOW_SELECT = 5;
    localparam int TM_CHAIN_ENABLE = 5;
    localparam int ED_DISABLE_BIT  = 11;
    localparam int P2_MDIX_DISABLE = 13;
    localparam int P2_POWER_SAVE   = 10;
    localparam int P2_REMOTE_LOOP  = 2;

    // Cable diagnostic fields
    localparam int CD_START        = 15;
    localparam int CD_RESULT_HI    = 14;
    localparam int CD_RESULT_LO    = 13;
    localparam int CD_DIST_HI      = 8;

    // Reset values
    localparam logic [15:0] BASIC_CONTROL_RESET  = 16'h3100;
    localparam logic [15:0] ENERGY_DETECT_RESET  = 16'h0800;
    localparam logic [15:0] ZERO_RESET           = 16'h0000;

    // Diagnostic result codes
    localparam logic [1:0] RESULT_NORMAL  = 2'h0;
    localparam logic [1:0] RESULT_OPEN    = 2'h1;
    localparam logic [1:0] RESULT_SHORT   = 2'h2;
    localparam logic [1:0] RESULT_INVALID = 2'h3;

    // Diagnostic timing: quiet wait before the pulse and echo window
    localparam int CLK_PERIOD_NS   = 20;
    localparam int QUIET_WAIT_NS   = 2000;
    localparam int QUIET_CYCLES    = QUIET_WAIT_NS / CLK_PERIOD_NS;
    localparam int ECHO_WINDOW_NS  = 10220;
    localparam int ECHO_CYCLES     = ECHO_WINDOW_NS / CLK_PERIOD_NS;

    // Number of chain inputs
    localparam int CHAIN_INPUTS    = 17;

    typedef enum logic [2:0] {
        DIAG_IDLE,
        DIAG_QUIET,
        DIAG_PULSE,
        DIAG_LISTEN,
        DIAG_DONE
    } diag_state_t;

endpackage : phy_test_pkg

// file: core/nand_chain.sv
`timescale 1ns/1ps
module nand_chain
    import phy_test_pkg::*;
#(
    parameter int N = CHAIN_INPUTS
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    // Chain inputs, index 0 first in test order
    input  wire logic [N-1:0] chain_in,
    // Chain result
    output logic              chain_out
);

    ////////////////////////////////////////////////////////////////////////
    logic [N-1:0] stage;

    // First gate sees one input tied high, so its output is the inverse
    assign stage[0] = ~(chain_in[0] & 1'b1);
    genvar g;
    generate
        for (g = 1; g < N; g++) begin : g_stage
            assign stage[g] = ~(stage[g-1] & chain_in[g]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Registered result: all high gives high, first fall drives it low
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            chain_out <= 1'b0;
        end else begin
            chain_out <= ~stage[N-1];
        end
    end

endmodule : nand_chain

// file: tb/phy_test_props.sv
`timescale 1ns/1ps
module phy_test_props
    import phy_test_pkg::*;
#(
    parameter int QUIET_CNT = QUIET_CYCLES,
    parameter int ECHO_CNT  = ECHO_CYCLES
) (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RESET_N,
    // Register bus
    input wire logic        REG_WR,
    input wire logic [4:0]  REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    // Status and controls
    input wire logic        LINK_100_FULL,
    input wire logic        REFLECT_PULSE,
    input wire logic        PARTNER_QUIET_REQ,
    input wire logic        LOCAL_LOOP_EN,
    input wire logic        LOCAL_COPPER_TX_EN,
    input wire logic        REMOTE_LOOP_EN,
    input wire logic        SPEED_100,
    input wire logic        CORE_POWER_DOWN,
    input wire logic        SLOW_OSC_SELECT,
    input wire logic        SOFT_RESET_PULSE
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);
    ////////////////////////////////////////////////////////////
    int   busy_cnt;
    logic wr_basic;
    assign wr_basic = REG_WR && (REG_ADDR == ADDR_BASIC_CONTROL) && !REG_WDATA[BC_SOFT_RESET];
    // Cycles spent with the quiet request up
    always_ff @(posedge CLK) begin
        if (!RESET_N || !PARTNER_QUIET_REQ) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy_cnt + 1;
        end
    end
    ////////////////////////////////////////////////////////////
    property p_start_quiet;
        REG_WR && REG_ADDR == ADDR_CABLE_DIAG && REG_WDATA[CD_START] && !PARTNER_QUIET_REQ |=> PARTNER_QUIET_REQ;
    endproperty
    a_start_quiet: assert property (p_start_quiet) else $error("start did not raise quiet request");
    property p_pulse_once;
        REFLECT_PULSE |=> !REFLECT_PULSE;
    endproperty
    a_pulse_once: assert property (p_pulse_once) else $error("pulse longer than one cycle");
    property p_pulse_time;
        REFLECT_PULSE |-> PARTNER_QUIET_REQ && busy_cnt >= QUIET_CNT - 1 && busy_cnt <= QUIET_CNT + 4;
    endproperty
    a_pulse_time: assert property (p_pulse_time) else $error("pulse outside quiet window");
    property p_diag_len;
        PARTNER_QUIET_REQ |-> busy_cnt <= QUIET_CNT + ECHO_CNT + 8;
    endproperty
    a_diag_len: assert property (p_diag_len) else $error("diagnostic never completed");
    property p_soft_reset;
        REG_WR && REG_ADDR == ADDR_BASIC_CONTROL && REG_WDATA[BC_SOFT_RESET]
            |=> SOFT_RESET_PULSE ##1 !SOFT_RESET_PULSE;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset pulse wrong");
    property p_power_down;
        wr_basic |=> ##1 CORE_POWER_DOWN == $past(REG_WDATA[BC_POWER_DOWN], 2);
    endproperty
    a_power_down: assert property (p_power_down) else $error("power down not following bit");
    property p_loopback;
        wr_basic |=> ##1 LOCAL_LOOP_EN == $past(REG_WDATA[BC_LOOPBACK], 2);
    endproperty
    a_loopback: assert property (p_loopback) else $error("loopback not following bit");
    property p_speed;
        wr_basic |=> ##1 SPEED_100 == $past(REG_WDATA[BC_SPEED_100], 2);
    endproperty
    a_speed: assert property (p_speed) else $error("speed not following bit");
    property p_slow_osc;
        REG_WR && REG_ADDR == ADDR_OSCILLATOR |=> ##1 SLOW_OSC_SELECT == $past(REG_WDATA[OSC_SLOW_SELECT], 2);
    endproperty
    a_slow_osc: assert property (p_slow_osc) else $error("slow oscillator not following bit");
    property p_remote;
        REMOTE_LOOP_EN |-> $past(LINK_100_FULL, 2) || $past(LINK_100_FULL, 3) || $past(LINK_100_FULL, 4);
    endproperty
    a_remote: assert property (p_remote) else $error("remote loopback without 100 full link");
    property p_copper;
        LOCAL_COPPER_TX_EN |-> LOCAL_LOOP_EN;
    endproperty
    a_copper: assert property (p_copper) else $error("copper copy without local loopback");
endmodule : phy_test_props
bind phy_test_ctrl phy_test_props #(
    .QUIET_CNT(QUIET_CNT),
    .ECHO_CNT (ECHO_CNT)
) phy_test_props_i (.*);

// file: tb/echo_model.sv
`timescale 1ns/1ps
module echo_model (
    // Clock, reset and scenario select
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [1:0] mode,
    input  wire logic [7:0] delay,
    // Device side
    input  wire logic       quiet_req,
    input  wire logic       pulse,
    output logic            line_energy,
    output logic            echo_seen,
    output logic            echo_short
);
    logic [7:0] cnt_reg;
    logic       run_reg;
    // Mode 3: partner keeps talking; modes 1 and 2 echo after delay cycles
    assign line_energy = (mode == 2'h3);
    assign echo_short  = echo_seen && (mode == 2'h2);
    always_ff @(posedge clk) begin
        if (!reset_n || !quiet_req) begin
            run_reg   <= 1'b0;
            cnt_reg   <= 8'h00;
            echo_seen <= 1'b0;
        end else if (pulse) begin
            run_reg <= 1'b1;
        end else if (run_reg) begin
            cnt_reg <= cnt_reg + 8'h01;
            if (cnt_reg == delay && mode inside {2'h1, 2'h2}) begin
                echo_seen <= 1'b1;
            end
        end
    end
endmodule : echo_model

// file: tb/tb.sv
`timescale 1ns/1ps
module tb
    import phy_test_pkg::*;
;
    logic        CLK, RESET_N, REG_WR, REG_RD, LINK_UP, LINK_100_FULL, RMII_MODE, CHAIN_STRAP_N;
    logic [4:0]  REG_ADDR;
    logic [15:0] REG_WDATA, REG_RDATA, rd_val;
    logic [16:0] CHAIN_PINS;
    logic        LINE_ENERGY, ECHO_SEEN, ECHO_SHORT, REFLECT_PULSE, PARTNER_QUIET_REQ;
    logic        CHAIN_OUTPUT_PIN, CHAIN_OUTPUT_OE_N, LOCAL_LOOP_EN, LOCAL_COPPER_TX_EN, REMOTE_LOOP_EN;
    logic        SPEED_100, FULL_DUPLEX, AUTONEG_EN, POWER_SAVE_ACTIVE, ENERGY_DETECT_POWERDOWN;
    logic        PLL_ENABLE, CORE_POWER_DOWN, SLOW_OSC_SELECT, SOFT_RESET_PULSE;
    logic [1:0]  echo_mode;
    logic [7:0]  echo_delay;
    int          n_fail, cmp_count, n_pulse, pulse_mark;
    logic [4:0]  rw_addrs [5] = '{ADDR_PLL_POWER, ADDR_OSCILLATOR, ADDR_TEST_MODE, ADDR_ENERGY_DETECT,
                                  ADDR_PHY_CONTROL_TWO};
    ////////////////////////////////////////////////////////////
    phy_test_ctrl #(.QUIET_CNT(4), .ECHO_CNT(20)) phy_test_ctrl_i (.*);
    echo_model echo_model_i (.clk(CLK), .reset_n(RESET_N), .mode(echo_mode), .delay(echo_delay),
        .quiet_req(PARTNER_QUIET_REQ), .pulse(REFLECT_PULSE), .line_energy(LINE_ENERGY),
        .echo_seen(ECHO_SEEN), .echo_short(ECHO_SHORT));
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        if (REFLECT_PULSE === 1'b1) n_pulse++;
    end
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic chk1(input logic seen, input logic exp);
        check({15'h0, seen}, {15'h0, exp});
    endtask : chk1
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge CLK);
        REG_WR    <= 1'b1;
        REG_ADDR  <= a;
        REG_WDATA <= d;
        @(posedge CLK);
        REG_WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a);
        @(posedge CLK);
        REG_RD   <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLK);
        REG_RD <= 1'b0;
        #1;
        rd_val = REG_RDATA;
    endtask : rd
    task automatic wait_n(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : wait_n
    task automatic results;
        if (n_fail == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results
    initial begin
        repeat (20000) @(posedge CLK);
        n_fail++;
        results;
    end
    ////////////////////////////////////////////////////////////
    initial begin
        {RESET_N, REG_WR, REG_RD, LINK_UP, LINK_100_FULL, RMII_MODE} = 6'h00;
        {REG_ADDR, REG_WDATA, echo_mode, echo_delay} = '0;
        {CHAIN_STRAP_N, CHAIN_PINS} = 18'h3ffff;
        {n_fail, cmp_count, n_pulse} = '0;
        repeat (12) @(posedge CLK);
        RESET_N <= 1'b1;
        wait_n(4);
        check({4'h0, SPEED_100, FULL_DUPLEX, AUTONEG_EN, PLL_ENABLE, LOCAL_LOOP_EN, LOCAL_COPPER_TX_EN,
               REMOTE_LOOP_EN, POWER_SAVE_ACTIVE, ENERGY_DETECT_POWERDOWN, CORE_POWER_DOWN, SLOW_OSC_SELECT,
               SOFT_RESET_PULSE}, 16'h0f00);
        rd(ADDR_BASIC_CONTROL);
        check(rd_val, BASIC_CONTROL_RESET);
        rd(ADDR_ENERGY_DETECT);
        check(rd_val, ENERGY_DETECT_RESET);
        foreach (rw_addrs[i]) begin
            wr(rw_addrs[i], 16'h5a5a);
            rd(rw_addrs[i]);
            check(rd_val, 16'h5a5a);
            wr(rw_addrs[i], (rw_addrs[i] == ADDR_ENERGY_DETECT) ? ENERGY_DETECT_RESET : ZERO_RESET);
        end
        wr(5'h05, 16'hffff);
        rd(5'h05);
        check(rd_val, 16'h0000);
        // Local loopback, 10 Mbps forced
        wr(ADDR_BASIC_CONTROL, 16'h4100);
        wait_n(5);
        check({12'h0, LOCAL_LOOP_EN, SPEED_100, AUTONEG_EN, FULL_DUPLEX}, 16'h0009);
        chk1(LOCAL_COPPER_TX_EN, 1'b1);
        @(posedge CLK);
        RMII_MODE <= 1'b1;
        wait_n(6);
        chk1(LOCAL_COPPER_TX_EN, 1'b0);
        wr(ADDR_BASIC_CONTROL, 16'h6000);
        wait_n(5);
        check({14'h0, SPEED_100, FULL_DUPLEX}, 16'h0002);
        // Remote loopback only with a 100 full-duplex link
        wr(ADDR_BASIC_CONTROL, 16'h2100);
        wr(ADDR_PHY_CONTROL_TWO, 16'h0004);
        wait_n(6);
        chk1(REMOTE_LOOP_EN, 1'b0);
        @(posedge CLK);
        LINK_100_FULL <= 1'b1;
        wait_n(6);
        chk1(REMOTE_LOOP_EN, 1'b1);
        // Cable test: normal, open, short, active partner refused
        wr(ADDR_PHY_CONTROL_TWO, 16'h2000);
        for (int m = 0; m < 4; m++) begin
            echo_mode  <= m[1:0];
            echo_delay <= 8'(3 + 3 * m);
            pulse_mark = n_pulse;
            wr(ADDR_CABLE_DIAG, 16'h8000);
            rd(ADDR_CABLE_DIAG);
            chk1(rd_val[CD_START], 1'b1);
            for (int k = 0; k < 50 && rd_val[CD_START] !== 1'b0; k++) rd(ADDR_CABLE_DIAG);
            if (rd_val[CD_START] !== 1'b0) begin
                n_fail++;
                results;
            end
            check({14'h0, rd_val[14:13]}, {14'h0, m[1:0]});
            if (m == 0) check({7'h0, rd_val[8:0]}, 16'h0000);
            if (m == 1 || m == 2) chk1(rd_val[8:0] >= echo_delay && rd_val[8:0] <= echo_delay + 6, 1'b1);
            if (m == 3) check(16'(n_pulse - pulse_mark), 16'h0000);
        end
        // Chain test via register, then via strap
        wr(ADDR_TEST_MODE, 16'h0020);
        for (int k = 0; k <= CHAIN_INPUTS; k++) begin
            @(posedge CLK);
            CHAIN_PINS <= 17'h1ffff << k;
            wait_n(6);
            chk1(CHAIN_OUTPUT_OE_N, 1'b0);
            chk1(CHAIN_OUTPUT_PIN, ~k[0]);
        end
        wr(ADDR_TEST_MODE, 16'h0000);
        CHAIN_STRAP_N <= 1'b0;
        wait_n(6);
        chk1(CHAIN_OUTPUT_OE_N, 1'b0);
        @(posedge CLK);
        CHAIN_STRAP_N <= 1'b1;
        wait_n(6);
        chk1(CHAIN_OUTPUT_OE_N, 1'b1);
        // Power modes and exit sequence
        wr(ADDR_BASIC_CONTROL, 16'h3100);
        wr(ADDR_PHY_CONTROL_TWO, 16'h0400);
        wait_n(5);
        chk1(POWER_SAVE_ACTIVE, 1'b1);
        @(posedge CLK);
        LINK_UP <= 1'b1;
        wait_n(6);
        chk1(POWER_SAVE_ACTIVE, 1'b0);
        @(posedge CLK);
        LINK_UP <= 1'b0;
        wr(ADDR_ENERGY_DETECT, 16'h0000);
        wait_n(6);
        check({14'h0, ENERGY_DETECT_POWERDOWN, PLL_ENABLE}, 16'h0003);
        wr(ADDR_PLL_POWER, 16'h0010);
        wait_n(5);
        chk1(PLL_ENABLE, 1'b0);
        wr(ADDR_BASIC_CONTROL, 16'h3900);
        wr(ADDR_OSCILLATOR, 16'h0020);
        wait_n(5);
        check({14'h0, CORE_POWER_DOWN, SLOW_OSC_SELECT}, 16'h0003);
        wr(ADDR_OSCILLATOR, 16'h0000);
        wr(ADDR_BASIC_CONTROL, 16'h2100);
        wait_n(5);
        check({14'h0, CORE_POWER_DOWN, SLOW_OSC_SELECT}, 16'h0000);
        wr(ADDR_BASIC_CONTROL, 16'h8000);
        wait_n(3);
        rd(ADDR_BASIC_CONTROL);
        check(rd_val, BASIC_CONTROL_RESET);
        results;
    end
endmodule : tb
